/* sor_consts.svh */
// Register offsets, field positions, reset values and frame counts.
`ifndef SOR_CONSTS_SVH
`define SOR_CONSTS_SVH
`define SOR_ADDR_PAT2_LO 13'h001b
`define SOR_ADDR_PAT2_HI 13'h001c
`define SOR_ADDR_STREAM 13'h0021
`define SOR_ADDR_CHAN 13'h0022
`define SOR_RST_BYTE 8'h00
`define SOR_RST_RES 3'h0
`define SOR_RST_WORD 4'h8
`define SOR_STREAM_LSB_BIT 7
`define SOR_STREAM_LOWRATE_BIT 3
`define SOR_STREAM_RES_HI 2
`define SOR_STREAM_RES_LO 0
`define SOR_CHAN_RST_BIT 1
`define SOR_CHAN_PD_BIT 0
`define SOR_SYNC_RST 7'h01
`define SOR_SPI_RW_BIT 15
`define SOR_SPI_INSTR_LAST 5'h0f
`define SOR_SPI_DATA_FIRST 5'h10
`define SOR_SPI_DATA_LAST 5'h17
`define SOR_SPI_END 5'h18
`endif

/* sor_pkg.sv */
// State types of the serial output configuration block.
package sor_pkg;
    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [7:0] pat_lo;
        logic [7:0] pat_hi;
        logic lsb_first;
        logic low_rate;
        logic [2:0] res;
        logic [3:0] word_bits;
        logic [3:0] ch_rst;
        logic [3:0] ch_pd;
    } sor_regs_st_t;
    typedef struct packed {
        logic sclk_p;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [7:0] dout;
        logic load;
        logic rd;
        logic sdo;
        logic oe;
        logic wr;
        logic [12:0] addr;
        logic [7:0] wdata;
    } sor_spi_st_t;
endpackage

/* sor_reg_if.sv */
// Register access carrier between the serial port and the register bank.
`timescale 1ns/100ps
`default_nettype none
interface sor_reg_if;
    logic wr_stb;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport spi (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* sor_spi_slave.sv */
// Serial port deframer: instruction, address and one data byte.
`timescale 1ns/100ps
`default_nettype none
`include "sor_consts.svh"
module sor_spi_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sdi,
    sor_reg_if.spi bus,
    output logic sdo,
    output logic sdo_oe
);
    sor_pkg::sor_spi_st_t st_q;
    sor_pkg::sor_spi_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.wr = 1'h0;
        st_d.load = 1'h0;
        st_d.sclk_p = sclk;
        if (csb_n) begin
            st_d.cnt = 5'h00;
            st_d.oe = 1'h0;
            st_d.rd = 1'h0;
        end else begin
            if (st_q.load) begin
                st_d.dout = bus.rdata;
            end
            if (sclk && !st_q.sclk_p && st_q.cnt != `SOR_SPI_END) begin
                st_d.sh = {st_q.sh[14:0], sdi};
                st_d.cnt = st_q.cnt + 5'h01;
                if (st_q.cnt == `SOR_SPI_INSTR_LAST) begin
                    st_d.addr = st_d.sh[12:0];
                    st_d.rd = st_d.sh[`SOR_SPI_RW_BIT];
                    st_d.load = st_d.sh[`SOR_SPI_RW_BIT];
                end
                if (st_q.cnt == `SOR_SPI_DATA_LAST && !st_q.rd) begin
                    st_d.wr = 1'h1;
                    st_d.wdata = st_d.sh[7:0];
                end
            end
            if (!sclk && st_q.sclk_p && st_q.rd &&
                st_q.cnt >= `SOR_SPI_DATA_FIRST &&
                st_q.cnt <= `SOR_SPI_DATA_LAST) begin
                st_d.sdo = st_q.dout[7];
                st_d.dout = {st_q.dout[6:0], 1'h0};
                st_d.oe = 1'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.wr_stb = st_q.wr;
    assign bus.addr = st_q.addr;
    assign bus.wdata = st_q.wdata;
    assign sdo = st_q.sdo;
    assign sdo_oe = st_q.oe;
endmodule
`default_nettype wire

/* sor_regs.sv */
// Serial output configuration register bank with its serial port.
`timescale 1ns/100ps
`default_nettype none
`include "sor_consts.svh"
module sor_regs (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CSB_N,
    input wire logic SCLK,
    input wire logic SDIO_I,
    output logic SDIO_O,
    output logic SDIO_OE,
    input wire logic [3:0] CHAN_SEL,
    output logic [15:0] PATTERN_TWO,
    output logic LSB_FIRST,
    output logic LOW_RATE_MODE,
    output logic [2:0] RESOLUTION,
    output logic [3:0] WORD_BITS,
    output logic [3:0] CH_OUT_RESET,
    output logic [3:0] CH_POWER_DOWN
);
    sor_pkg::sor_regs_st_t st_q;
    sor_pkg::sor_regs_st_t st_d;
    sor_reg_if bus ();
    logic [3:0] chan_sel;

    // Maps the resolution code to the serial word length in bits.
    function automatic logic [3:0] word_len(input logic [2:0] code);
        logic [3:0] bits;
        bits = 4'h8;
        case (code)
            3'h2: bits = 4'ha;
            3'h3: bits = 4'hc;
            3'h4: bits = 4'he;
            default: bits = 4'h8;
        endcase
        return bits;
    endfunction

    assign chan_sel = st_q.sync2[6:3];

    sor_spi_slave u_spi (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .csb_n(st_q.sync2[0]),
        .sclk(st_q.sync2[1]),
        .sdi(st_q.sync2[2]),
        .bus(bus),
        .sdo(SDIO_O),
        .sdo_oe(SDIO_OE)
    );

    // Read data; channel reads show the lowest selected channel.
    always_comb begin
        logic [1:0] ch;
        ch = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (chan_sel[i]) begin
                ch = 2'(i);
            end
        end
        case (bus.addr)
            `SOR_ADDR_PAT2_LO: bus.rdata = st_q.pat_lo;
            `SOR_ADDR_PAT2_HI: bus.rdata = st_q.pat_hi;
            `SOR_ADDR_STREAM: bus.rdata = {st_q.lsb_first, 3'h0,
                st_q.low_rate, st_q.res};
            `SOR_ADDR_CHAN: bus.rdata = {6'h00, st_q.ch_rst[ch],
                st_q.ch_pd[ch]};
            default: bus.rdata = 8'h00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.sync1 = {CHAN_SEL, SDIO_I, SCLK, CSB_N};
        st_d.sync2 = st_q.sync1;
        if (bus.wr_stb) begin
            case (bus.addr)
                `SOR_ADDR_PAT2_LO: st_d.pat_lo = bus.wdata;
                `SOR_ADDR_PAT2_HI: st_d.pat_hi = bus.wdata;
                `SOR_ADDR_STREAM: begin
                    st_d.lsb_first = bus.wdata[`SOR_STREAM_LSB_BIT];
                    st_d.low_rate = bus.wdata[`SOR_STREAM_LOWRATE_BIT];
                    st_d.res = bus.wdata[`SOR_STREAM_RES_HI:
                        `SOR_STREAM_RES_LO];
                end
                `SOR_ADDR_CHAN: begin
                    for (int i = 0; i < 4; i++) begin
                        if (chan_sel[i]) begin
                            st_d.ch_rst[i] =
                                bus.wdata[`SOR_CHAN_RST_BIT];
                            st_d.ch_pd[i] =
                                bus.wdata[`SOR_CHAN_PD_BIT];
                        end
                    end
                end
                default: st_d.pat_lo = st_q.pat_lo;
            endcase
        end
        st_d.word_bits = word_len(st_d.res);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q.sync1 <= `SOR_SYNC_RST;
            st_q.sync2 <= `SOR_SYNC_RST;
            st_q.pat_lo <= `SOR_RST_BYTE;
            st_q.pat_hi <= `SOR_RST_BYTE;
            st_q.lsb_first <= 1'h0;
            st_q.low_rate <= 1'h0;
            st_q.res <= `SOR_RST_RES;
            st_q.word_bits <= `SOR_RST_WORD;
            st_q.ch_rst <= 4'h0;
            st_q.ch_pd <= 4'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign PATTERN_TWO = {st_q.pat_hi, st_q.pat_lo};
    assign LSB_FIRST = st_q.lsb_first;
    assign LOW_RATE_MODE = st_q.low_rate;
    assign RESOLUTION = st_q.res;
    assign WORD_BITS = st_q.word_bits;
    assign CH_OUT_RESET = st_q.ch_rst;
    assign CH_POWER_DOWN = st_q.ch_pd;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    chk_pattern_low_write: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_PAT2_LO |=>
        PATTERN_TWO[7:0] == $past(bus.wdata) &&
        $stable(PATTERN_TWO[15:8]))
        else $error("Low pattern byte not stored.");

    chk_pattern_low_hold: assert property (
        !(bus.wr_stb && bus.addr == `SOR_ADDR_PAT2_LO) |=>
        $stable(PATTERN_TWO[7:0]))
        else $error("Low pattern byte changed without a write.");
    chk_pattern_high_write: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_PAT2_HI |=>
        PATTERN_TWO[15:8] == $past(bus.wdata) &&
        $stable(PATTERN_TWO[7:0]))
        else $error("High pattern byte not stored.");

    chk_pattern_high_hold: assert property (
        !(bus.wr_stb && bus.addr == `SOR_ADDR_PAT2_HI) |=>
        $stable(PATTERN_TWO[15:8]))
        else $error("High pattern byte changed without a write.");
    chk_word_length_map: assert property (
        (RESOLUTION <= 3'h1 && WORD_BITS == 4'h8) ||
        (RESOLUTION == 3'h2 && WORD_BITS == 4'ha) ||
        (RESOLUTION == 3'h3 && WORD_BITS == 4'hc) ||
        (RESOLUTION == 3'h4 && WORD_BITS == 4'he) ||
        (RESOLUTION > 3'h4 && WORD_BITS == 4'h8))
        else $error("Word length does not match resolution code.");

    chk_word_length_track: assert property (
        $changed(WORD_BITS) |->
        $changed(RESOLUTION))
        else $error("Word length moved without a resolution change.");

    chk_stream_read_reserved: assert property (
        bus.addr == `SOR_ADDR_STREAM |->
        bus.rdata[6:4] == 3'h0)
        else $error("Reserved stream bits read as nonzero.");

    chk_chan_read_reserved: assert property (
        bus.addr == `SOR_ADDR_CHAN |->
        bus.rdata[7:2] == 6'h00)
        else $error("Reserved channel bits read as nonzero.");
    chk_channel_reset_set: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_CHAN && chan_sel[0] |=>
        CH_OUT_RESET[0] == $past(bus.wdata[`SOR_CHAN_RST_BIT]))
        else $error("Channel output reset not applied.");

    chk_channel_reset_two: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_CHAN && chan_sel[2] |=>
        CH_OUT_RESET[2] == $past(bus.wdata[`SOR_CHAN_RST_BIT]))
        else $error("Channel two output reset not applied.");

    chk_channel_reset_local: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_CHAN && !chan_sel[3] |=>
        $stable(CH_OUT_RESET[3]) && $stable(CH_POWER_DOWN[3]))
        else $error("Unselected channel three changed.");

    chk_channel_pd_set: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_CHAN && chan_sel[2] |=>
        CH_POWER_DOWN[2] == $past(bus.wdata[`SOR_CHAN_PD_BIT]))
        else $error("Channel power-down not applied.");
    chk_channel_pd_local: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_CHAN && !chan_sel[1] |=>
        $stable(CH_POWER_DOWN[1]) && $stable(CH_OUT_RESET[1]))
        else $error("Unselected channel changed.");

    chk_channel_hold: assert property (
        !(bus.wr_stb && bus.addr == `SOR_ADDR_CHAN) |=>
        $stable(CH_OUT_RESET) &&
        $stable(CH_POWER_DOWN))
        else $error("Channel control changed without a write.");
    chk_bit_order_write: assert property (
        bus.wr_stb && bus.addr == `SOR_ADDR_STREAM |=>
        LSB_FIRST == $past(bus.wdata[`SOR_STREAM_LSB_BIT]) &&
        RESOLUTION == $past(bus.wdata[2:0]))
        else $error("Bit order not stored.");

    chk_stream_hold: assert property (
        !(bus.wr_stb && bus.addr == `SOR_ADDR_STREAM) |=>
        $stable(LSB_FIRST) && $stable(LOW_RATE_MODE) &&
        $stable(RESOLUTION))
        else $error("Stream control changed without a write.");

    chk_pin_release: assert property (
        st_q.sync2[0] |=>
        !SDIO_OE)
        else $error("Data pin still driven while deselected.");

    cov_pattern_write: cover property (
        bus.wr_stb && bus.addr == `SOR_ADDR_PAT2_HI);
    cov_word_fourteen: cover property (WORD_BITS == 4'he);
    cov_channel_down: cover property ($rose(CH_POWER_DOWN[0]));
    cov_read_out: cover property ($rose(SDIO_OE));
    cov_channel_reset: cover property ($rose(CH_OUT_RESET[2]));
endmodule
`default_nettype wire

/* sor_regs_test.sv */
// Self-checking testbench of the serial output configuration registers.
`timescale 1ns/100ps
`default_nettype none
`include "sor_consts.svh"
module sor_regs_test;
    logic REF_CLK = 1'h0;
    logic RST_N = 1'h0;
    logic CSB_N = 1'h1;
    logic SCLK = 1'h0;
    logic sdio_drv = 1'h0;
    logic [3:0] CHAN_SEL = 4'h0;
    logic SDIO_I;
    logic SDIO_O;
    logic SDIO_OE;
    logic LSB_FIRST;
    logic LOW_RATE_MODE;
    logic [2:0] RESOLUTION;
    logic [3:0] WORD_BITS;
    logic [3:0] CH_OUT_RESET;
    logic [3:0] CH_POWER_DOWN;
    logic [15:0] PATTERN_TWO;
    logic [7:0] q;
    int mismatches = 0;
    int samples_checked = 0;

    // The shared data pin carries the device's bit while it drives.
    assign SDIO_I = SDIO_OE ? SDIO_O : sdio_drv;

    always #12.5 REF_CLK = ~REF_CLK;

    sor_regs i_dut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .CSB_N(CSB_N), .SCLK(SCLK),
        .SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE),
        .CHAN_SEL(CHAN_SEL), .PATTERN_TWO(PATTERN_TWO),
        .LSB_FIRST(LSB_FIRST), .LOW_RATE_MODE(LOW_RATE_MODE),
        .RESOLUTION(RESOLUTION), .WORD_BITS(WORD_BITS),
        .CH_OUT_RESET(CH_OUT_RESET), .CH_POWER_DOWN(CH_POWER_DOWN)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic summarize;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One 24-bit frame; read data is taken late in each of the last eight low phases.
    task automatic spi(input logic rd, input logic [12:0] a,
                       input logic [7:0] wd, output logic [7:0] rq);
        logic [23:0] fr;
        fr = {rd, 2'h0, a, wd};
        rq = 8'h00;
        @(posedge REF_CLK) CSB_N <= 1'h0;
        cyc(4);
        for (int i = 23; i >= 0; i--) begin
            @(posedge REF_CLK) begin
                SCLK <= 1'h0;
                sdio_drv <= fr[i];
            end
            cyc(5);
            @(negedge REF_CLK) if (i < 8) rq[i] = SDIO_O;
            @(posedge REF_CLK) SCLK <= 1'h1;
            cyc(5);
        end
        @(posedge REF_CLK) SCLK <= 1'h0;
        cyc(5);
        @(posedge REF_CLK) CSB_N <= 1'h1;
        cyc(6);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] nq;
        spi(1'h0, a, d, nq);
    endtask

    function automatic logic [3:0] wbits(input logic [2:0] c);
        case (c)
            3'h2: return 4'ha;
            3'h3: return 4'hc;
            3'h4: return 4'he;
            default: return 4'h8;
        endcase
    endfunction

    task automatic t_reset;
        chk({LSB_FIRST, LOW_RATE_MODE, RESOLUTION}, 16'h0000,
            "stream");
        chk(WORD_BITS, 16'h0008, "word bits");
        chk({CH_OUT_RESET, CH_POWER_DOWN}, 16'h0000,
            "chan");
        chk(PATTERN_TWO, 16'h0000, "pattern");
        spi(1'h1, `SOR_ADDR_PAT2_HI, 8'h00, q);
        chk(q, 16'h0000, "high read");
        spi(1'h1, `SOR_ADDR_STREAM, 8'h00, q);
        chk(q, 16'h0000, "stream read");
        chk(SDIO_OE, 16'h0000, "pin released");
    endtask

    task automatic t_pattern;
        wr(`SOR_ADDR_PAT2_LO, 8'ha5);
        chk(PATTERN_TWO, 16'h00a5, "low byte");
        wr(`SOR_ADDR_PAT2_HI, 8'h3c);
        chk(PATTERN_TWO, 16'h3ca5, "high byte");
        spi(1'h1, `SOR_ADDR_PAT2_LO, 8'h00, q);
        chk(q, 16'h00a5, "low read");
        spi(1'h1, `SOR_ADDR_PAT2_HI, 8'h00, q);
        chk(q, 16'h003c, "high read");
    endtask

    task automatic t_stream;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            wr(`SOR_ADDR_STREAM, {c[0], 3'h7, c[1], c});
            chk(RESOLUTION, {13'h0000, c}, "res");
            chk(WORD_BITS, {12'h000, wbits(c)}, "word");
            chk(LSB_FIRST, {15'h0000, c[0]}, "order");
            chk(LOW_RATE_MODE, {15'h0000, c[1]}, "low rate");
            spi(1'h1, `SOR_ADDR_STREAM, 8'h00, q);
            chk(q, {8'h00, c[0], 3'h0, c[1], c}, "stream read");
        end
    endtask

    task automatic t_chan;
        @(posedge REF_CLK) CHAN_SEL <= 4'h5;
        wr(`SOR_ADDR_CHAN, 8'h03);
        chk({CH_OUT_RESET, CH_POWER_DOWN}, 16'h0055,
            "sel 5");
        @(posedge REF_CLK) CHAN_SEL <= 4'h2;
        wr(`SOR_ADDR_CHAN, 8'h01);
        chk({CH_OUT_RESET, CH_POWER_DOWN}, 16'h0057,
            "sel 2");
        spi(1'h1, `SOR_ADDR_CHAN, 8'h00, q);
        chk(q, 16'h0001, "chan 1 read");
        @(posedge REF_CLK) CHAN_SEL <= 4'h0;
        spi(1'h1, `SOR_ADDR_CHAN, 8'h00, q);
        chk(q, 16'h0003, "chan 0 read");
    endtask

    task automatic t_unmapped;
        wr(13'h0030, 8'hff);
        chk(PATTERN_TWO, 16'h3ca5, "no side effect");
        spi(1'h1, 13'h0030, 8'h00, q);
        chk(q, 16'h0000, "unmapped read");
    endtask

    initial begin
        cyc(5);
        @(posedge REF_CLK) RST_N <= 1'h1;
        cyc(4);
        t_reset();
        t_pattern();
        t_stream();
        t_chan();
        t_unmapped();
        summarize();
    end

    initial begin
        cyc(40000);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
